// [hw/rdm_pkg.sv]
// remote dma and shared memory access: constants, types and register map
// assumes a single 20 MHz clock domain and an asynchronous buffer ram
//
// Functional notes
// R1: remote channel has three modes: remote write, remote read, send packet.
// R2: start address and byte count each come from a two-byte register pair.
// R3: remote write stores host port data at rising addresses, counting down.
// R4: remote write or read ends when the remaining count reaches zero.
// R5: remote read fetches rising addresses into the host port, counting down.
// R6: send packet loads address from boundary, count from the frame header.
// R7: after send packet the boundary moves on to free the consumed pages.
// R8: in remote read and send packet, address reaching page stop reloads with page start; remote write does not wrap.
// R9: host writes 0x0F to the upper count byte before send packet.
// R10: a host read before the latch fills is stalled until data is present.
// R11: the host read strobe acknowledges the word and lets the next fetch start.
// R12: remote dma arbitrates per word and releases ram after each word.
// R13: remote ram access waits while a local transfer is under way.
// R14: remote write refuses more host data until the latch is moved.
// R15: in shared memory mode software keeps the remote dma idle.
// R16: shared access during a local transfer is held with wait states.
// R17: shared access started first finishes before a local transfer begins.
// R18: shared accesses are answered only while enable bit 6 is set.
// R19: narrow host: base from control one only, address bit 19 must be one.
// R20: base compares bits 13..18, skipping 0, 1, 2 or 3 low bits by window size.
// R21: wide host: base from both control registers, bit 19 from the base.
// R22: shared cycle completes at once when idle, data over the memory bus.
// R23: port transfers are bytes, or words when word select and wide pin agree.
// R24: in word mode each port access lowers the count by two.
package rdm_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_SADDR_LO = 8'h08;
  localparam logic [7:0] OFS_SADDR_HI = 8'h0C;
  localparam logic [7:0] OFS_CNT_LO   = 8'h10;
  localparam logic [7:0] OFS_CNT_HI   = 8'h14;
  localparam logic [7:0] OFS_BOUND    = 8'h18;
  localparam logic [7:0] OFS_PSTART   = 8'h1C;
  localparam logic [7:0] OFS_PSTOP    = 8'h20;
  localparam logic [7:0] OFS_CFG      = 8'h24;
  localparam logic [7:0] OFS_SMCTL1   = 8'h28;
  localparam logic [7:0] OFS_SMCTL2   = 8'h2C;
  localparam logic [7:0] OFS_STATUS   = 8'h30;
  localparam logic [7:0] OFS_CUR_ADDR = 8'h34;
  localparam logic [7:0] OFS_CUR_CNT  = 8'h38;
  // ==========================================================
  // field positions and values
  localparam int         CMD_ABORT_BIT = 7;
  localparam int         CFG_WTS_BIT   = 0;
  localparam int         SM_EN_BIT     = 6;
  localparam int         SM_B19_BIT    = 3;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [1:0] RESP_OK       = 2'b00;
  localparam logic [1:0] RESP_SLVERR   = 2'b10;
  localparam logic [15:0] STEP_BYTE    = 16'h0001;
  localparam logic [15:0] STEP_WORD    = 16'h0002;
  localparam logic [15:0] HDR_CNT_OFS  = 16'h0002;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_RD   = 2'b01,
    MODE_WR   = 2'b10,
    MODE_SEND = 2'b11
  } rdm_mode_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR0 = 3'b001,
    ST_HDR1 = 3'b011,
    ST_HDR2 = 3'b010,
    ST_HDR3 = 3'b110,
    ST_WAIT = 3'b111,
    ST_ACC  = 3'b101
  } rdm_state_e;
endpackage

// [hw/rdm_core.sv]
// remote dma channel, host data port and shared memory window for the buffer ram
// assumes an asynchronous buffer ram (read data valid while ram_en is high)
// and an external local dma that drives the ram only while ldma_gnt is high
`timescale 1ns/1ps
module rdm_core (
  input  wire logic        mclk,            // 20 MHz clock
  input  wire logic        rst_b,           // sync reset, active low
  input  wire logic [7:0]  awaddr,          // axi write address
  input  wire logic        awvalid,         // axi
  output logic             awready,         // axi
  input  wire logic [31:0] wdata,           // axi write data
  input  wire logic [3:0]  wstrb,           // axi byte enables
  input  wire logic        wvalid,          // axi
  output logic             wready,          // axi
  output logic [1:0]       bresp,           // axi
  output logic             bvalid,          // axi
  input  wire logic        bready,          // axi
  input  wire logic [7:0]  araddr,          // axi read address
  input  wire logic        arvalid,         // axi
  output logic             arready,         // axi
  output logic [31:0]      rdata,           // axi read data
  output logic [1:0]       rresp,           // axi
  output logic             rvalid,          // axi
  input  wire logic        rready,          // axi
  input  wire logic        host_width_select_pin, // wide host bus
  input  wire logic        port_rd,         // host port read, held until ack
  input  wire logic        port_wr,         // host port write, held until ack
  input  wire logic [15:0] port_wdata,      // host port write data
  output logic [15:0]      port_rdata,      // host port read data
  output logic             port_ack,        // port access done, pulse
  output logic             port_wait,       // port access stalled
  input  wire logic        smem_req,        // host memory access, held until ack
  input  wire logic        smem_we,         // host memory write
  input  wire logic [23:0] smem_addr,       // host memory byte address
  input  wire logic [1:0]  smem_be,         // host byte lanes
  input  wire logic [15:0] smem_wdata,      // host memory write data
  output logic [15:0]      smem_rdata,      // host memory read data
  output logic             smem_ack,        // memory access done, pulse
  output logic             smem_wait,       // memory access held off
  input  wire logic        ldma_req,        // local dma wants the ram
  output logic             ldma_gnt,        // local dma owns the ram
  output logic             ram_en,          // ram access strobe
  output logic             ram_we,          // ram write
  output logic [15:0]      ram_addr,        // ram byte address
  output logic [1:0]       ram_be,          // ram byte lanes
  output logic [15:0]      ram_wdata,       // ram write data
  input  wire logic [15:0] ram_rdata        // ram read data
);
  // ==========================================================
  // declarations
  logic [7:0]  saddr_lo_reg, saddr_hi_reg, cnt_lo_reg, cnt_hi_reg;
  logic [7:0]  bound_reg, pstart_reg, pstop_reg, cfg_reg, smctl1_reg, smctl2_reg;
  logic [15:0] cur_addr_reg, cur_cnt_reg, latch_reg;
  logic        latch_full_reg, sm_acc_reg, rem_acc_reg;
  logic [7:0]  next_page_reg;
  rdm_pkg::rdm_mode_e  mode_reg;
  rdm_pkg::rdm_state_e state_reg, state_next;
  logic        wr_fire, rd_fire, cmd_go, cmd_abort, word_mode, ram_free;
  logic        sm_hit, sm_start, rem_issue, wr_ok, rd_ok;
  logic [15:0] step, cnt_dec, addr_inc, win_mask;
  logic [7:0]  rsel_byte;

  // ==========================================================
  // axi4-lite slave: both write channels are taken together
  assign wr_fire   = awready && awvalid && wvalid;
  assign rd_fire   = arready && arvalid;
  assign cmd_go    = wr_fire && awaddr == rdm_pkg::OFS_CMD && wstrb[0] && mode_reg == rdm_pkg::MODE_NONE;
  assign cmd_abort = wr_fire && awaddr == rdm_pkg::OFS_CMD && wstrb[0] && wdata[rdm_pkg::CMD_ABORT_BIT];

  // write handshake: ready for one cycle, response after
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= rdm_pkg::RESP_OK;
    end else begin
      awready <= !awready && !bvalid && awvalid && wvalid;
      wready  <= !awready && !bvalid && awvalid && wvalid;
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= (awaddr > rdm_pkg::OFS_CUR_CNT || awaddr[1:0] != 2'b00) ? rdm_pkg::RESP_SLVERR
                                                                         : rdm_pkg::RESP_OK;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // software registers, low byte lane only; upper bits read as zero
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      saddr_lo_reg <= rdm_pkg::RST_BYTE;
      saddr_hi_reg <= rdm_pkg::RST_BYTE;
      cnt_lo_reg   <= rdm_pkg::RST_BYTE;
      cnt_hi_reg   <= rdm_pkg::RST_BYTE;
      pstart_reg   <= rdm_pkg::RST_BYTE;
      pstop_reg    <= rdm_pkg::RST_BYTE;
      cfg_reg      <= rdm_pkg::RST_BYTE;
      smctl1_reg   <= rdm_pkg::RST_BYTE;
      smctl2_reg   <= rdm_pkg::RST_BYTE;
    end else if (wr_fire && wstrb[0]) begin
      case (awaddr)
        rdm_pkg::OFS_SADDR_LO: saddr_lo_reg <= wdata[7:0]; // [R2]
        rdm_pkg::OFS_SADDR_HI: saddr_hi_reg <= wdata[7:0]; // [R2]
        rdm_pkg::OFS_CNT_LO:   cnt_lo_reg   <= wdata[7:0]; // [R2]
        rdm_pkg::OFS_CNT_HI:   cnt_hi_reg   <= wdata[7:0]; // [R2] [R9]
        rdm_pkg::OFS_PSTART:   pstart_reg   <= wdata[7:0];
        rdm_pkg::OFS_PSTOP:    pstop_reg    <= wdata[7:0];
        rdm_pkg::OFS_CFG:      cfg_reg      <= wdata[7:0];
        rdm_pkg::OFS_SMCTL1:   smctl1_reg   <= wdata[7:0];
        rdm_pkg::OFS_SMCTL2:   smctl2_reg   <= wdata[7:0];
        default: ;
      endcase
    end
  end

  // read mux; status shows the channel's live state
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= rdm_pkg::RESP_OK;
    end else begin
      arready <= !arready && !rvalid && arvalid;
      if (rd_fire) begin
        rvalid <= 1'b1;
        rresp  <= rdm_pkg::RESP_OK;
        case (araddr)
          rdm_pkg::OFS_CMD:      rdata <= {30'h0000_0000, mode_reg};
          rdm_pkg::OFS_SADDR_LO: rdata <= {24'h00_0000, saddr_lo_reg};
          rdm_pkg::OFS_SADDR_HI: rdata <= {24'h00_0000, saddr_hi_reg};
          rdm_pkg::OFS_CNT_LO:   rdata <= {24'h00_0000, cnt_lo_reg};
          rdm_pkg::OFS_CNT_HI:   rdata <= {24'h00_0000, cnt_hi_reg};
          rdm_pkg::OFS_BOUND:    rdata <= {24'h00_0000, bound_reg};
          rdm_pkg::OFS_PSTART:   rdata <= {24'h00_0000, pstart_reg};
          rdm_pkg::OFS_PSTOP:    rdata <= {24'h00_0000, pstop_reg};
          rdm_pkg::OFS_CFG:      rdata <= {24'h00_0000, cfg_reg};
          rdm_pkg::OFS_SMCTL1:   rdata <= {24'h00_0000, smctl1_reg};
          rdm_pkg::OFS_SMCTL2:   rdata <= {24'h00_0000, smctl2_reg};
          rdm_pkg::OFS_STATUS:   rdata <= {26'h000_0000, state_reg, latch_full_reg, ldma_gnt, word_mode};
          rdm_pkg::OFS_CUR_ADDR: rdata <= {16'h0000, cur_addr_reg};
          rdm_pkg::OFS_CUR_CNT:  rdata <= {16'h0000, cur_cnt_reg};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= rdm_pkg::RESP_SLVERR;
          end
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // remote dma channel
  assign word_mode = cfg_reg[rdm_pkg::CFG_WTS_BIT] && host_width_select_pin; // [R23]
  assign step      = word_mode ? rdm_pkg::STEP_WORD : rdm_pkg::STEP_BYTE;    // [R24]
  assign cnt_dec   = (cur_cnt_reg <= step) ? 16'h0000 : cur_cnt_reg - step;   // [R4]
  assign addr_inc  = cur_addr_reg + step;
  // remote may use the ram only when no local or shared cycle owns it
  assign ram_free  = !ldma_req && !ldma_gnt && !sm_hit && !sm_acc_reg;       // [R13] [R12]
  assign rd_ok     = mode_reg != rdm_pkg::MODE_WR && !latch_full_reg;
  assign wr_ok     = mode_reg == rdm_pkg::MODE_WR && latch_full_reg;

  // next state; every word is a fresh request, so the ram is let go in between
  always_comb begin
    state_next = state_reg;
    rem_issue  = 1'b0;
    case (state_reg)
      rdm_pkg::ST_IDLE: begin
        if (cmd_go && wdata[1:0] == rdm_pkg::MODE_SEND) begin
          state_next = rdm_pkg::ST_HDR0; // [R1]
        end else if (cmd_go && wdata[1:0] != rdm_pkg::MODE_NONE) begin
          state_next = rdm_pkg::ST_WAIT; // [R1]
        end
      end
      rdm_pkg::ST_HDR0: begin
        if (ram_free) begin
          state_next = rdm_pkg::ST_HDR1;
          rem_issue  = 1'b1;
        end
      end
      rdm_pkg::ST_HDR1: state_next = rdm_pkg::ST_HDR2;
      rdm_pkg::ST_HDR2: begin
        if (ram_free) begin
          state_next = rdm_pkg::ST_HDR3;
          rem_issue  = 1'b1;
        end
      end
      rdm_pkg::ST_HDR3: state_next = rdm_pkg::ST_WAIT;
      rdm_pkg::ST_WAIT: begin
        if (cur_cnt_reg == 16'h0000) begin
          state_next = rdm_pkg::ST_IDLE; // [R4]
        end else if (ram_free && (rd_ok || wr_ok)) begin
          state_next = rdm_pkg::ST_ACC; // [R10] [R14]
          rem_issue  = 1'b1;
        end
      end
      rdm_pkg::ST_ACC: state_next = (cnt_dec == 16'h0000) ? rdm_pkg::ST_IDLE : rdm_pkg::ST_WAIT; // [R4]
      default: state_next = rdm_pkg::ST_IDLE;
    endcase
    if (cmd_abort) begin
      state_next = rdm_pkg::ST_IDLE;
    end
  end

  // state, mode and boundary; send packet frees pages when it finishes
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= rdm_pkg::ST_IDLE;
      mode_reg  <= rdm_pkg::MODE_NONE;
      bound_reg <= rdm_pkg::RST_BYTE;
    end else begin
      state_reg <= state_next;
      // an abort written while idle must not leave a mode behind with the channel stopped
      if (state_reg == rdm_pkg::ST_IDLE && cmd_go && !cmd_abort) begin
        mode_reg <= rdm_pkg::rdm_mode_e'(wdata[1:0]);
      end else if (state_next == rdm_pkg::ST_IDLE) begin
        mode_reg <= rdm_pkg::MODE_NONE;
      end
      if (wr_fire && wstrb[0] && awaddr == rdm_pkg::OFS_BOUND) begin
        bound_reg <= wdata[7:0];
      end else if (mode_reg == rdm_pkg::MODE_SEND && state_reg == rdm_pkg::ST_WAIT
                   && state_next == rdm_pkg::ST_IDLE) begin
        bound_reg <= next_page_reg; // [R7]
      end else if (mode_reg == rdm_pkg::MODE_SEND && state_reg == rdm_pkg::ST_ACC
                   && state_next == rdm_pkg::ST_IDLE) begin
        bound_reg <= next_page_reg; // [R7]
      end
    end
  end

  // dma address and remaining count
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cur_addr_reg  <= 16'h0000;
      cur_cnt_reg   <= 16'h0000;
      next_page_reg <= rdm_pkg::RST_BYTE;
    end else if (state_reg == rdm_pkg::ST_IDLE && cmd_go) begin
      cur_addr_reg <= {saddr_hi_reg, saddr_lo_reg}; // [R2]
      cur_cnt_reg  <= {cnt_hi_reg, cnt_lo_reg};     // [R2]
      if (wdata[1:0] == rdm_pkg::MODE_SEND) begin
        cur_addr_reg <= {bound_reg, 8'h00}; // [R6]
      end
    end else if (state_reg == rdm_pkg::ST_HDR1) begin
      next_page_reg <= ram_rdata[15:8];
    end else if (state_reg == rdm_pkg::ST_HDR3) begin
      cur_cnt_reg <= ram_rdata; // [R6]
    end else if (state_reg == rdm_pkg::ST_ACC) begin
      cur_cnt_reg <= cnt_dec; // [R3] [R5] [R24]
      if (mode_reg != rdm_pkg::MODE_WR && addr_inc[15:8] == pstop_reg) begin
        cur_addr_reg <= {pstart_reg, 8'h00}; // [R8]
      end else begin
        cur_addr_reg <= addr_inc; // [R3] [R5]
      end
    end
  end

  // data latch between host port and ram; the host strobe is the fetch acknowledge
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      latch_reg      <= 16'h0000;
      latch_full_reg <= 1'b0;
      port_rdata     <= 16'h0000;
      port_ack       <= 1'b0;
      port_wait      <= 1'b0;
    end else begin
      port_ack  <= 1'b0;
      port_wait <= (port_rd || port_wr) && !port_ack;
      if (cmd_abort || (state_reg == rdm_pkg::ST_IDLE && cmd_go)) begin
        latch_full_reg <= 1'b0;
      end else if (state_reg == rdm_pkg::ST_ACC && mode_reg != rdm_pkg::MODE_WR) begin
        latch_reg      <= cur_addr_reg[0] && !word_mode ? {8'h00, ram_rdata[15:8]} : ram_rdata;
        latch_full_reg <= 1'b1; // [R5]
      end else if (state_reg == rdm_pkg::ST_ACC) begin
        latch_full_reg <= 1'b0; // [R14]
      end else if (port_rd && !port_ack && latch_full_reg && mode_reg != rdm_pkg::MODE_WR) begin
        port_rdata     <= latch_reg;
        port_ack       <= 1'b1; // [R10]
        port_wait      <= 1'b0;
        latch_full_reg <= 1'b0; // [R11]
      end else if (port_wr && !port_ack && !latch_full_reg && mode_reg == rdm_pkg::MODE_WR) begin
        latch_reg      <= port_wdata;
        port_ack       <= 1'b1; // [R14]
        port_wait      <= 1'b0;
        latch_full_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // shared memory window decode
  assign rsel_byte = host_width_select_pin ? smctl2_reg : 8'h00;
  always_comb begin
    sm_hit = smem_req && !smem_ack && smctl1_reg[rdm_pkg::SM_EN_BIT]; // [R18]
    if (host_width_select_pin) begin
      sm_hit = sm_hit && smem_addr[23:20] == rsel_byte[7:4]
               && smem_addr[19] == rsel_byte[rdm_pkg::SM_B19_BIT]; // [R21]
    end else begin
      sm_hit = sm_hit && smem_addr[23:20] == 4'h0 && smem_addr[19]; // [R19]
    end
    for (int i = 0; i < 6; i++) begin
      if (i >= int'(smctl2_reg[1:0]) || i > 2) begin
        sm_hit = sm_hit && smem_addr[13 + i] == smctl1_reg[i]; // [R20]
      end
    end
  end
  assign win_mask = 16'hFFFF >> (2'd3 - smctl2_reg[1:0]);
  // local wins a tie; a shared cycle already started keeps the ram
  assign sm_start = sm_hit && !sm_acc_reg && !ldma_req && !ldma_gnt && !rem_acc_reg; // [R16]

  // shared memory cycle and local dma grant
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sm_acc_reg  <= 1'b0;
      rem_acc_reg <= 1'b0;
      smem_ack    <= 1'b0;
      smem_wait   <= 1'b0;
      smem_rdata  <= 16'h0000;
      ldma_gnt    <= 1'b0;
    end else begin
      sm_acc_reg  <= sm_start;
      rem_acc_reg <= rem_issue;
      smem_ack    <= sm_acc_reg; // [R22]
      smem_wait   <= sm_hit && !sm_start && !sm_acc_reg; // [R16]
      if (sm_acc_reg) begin
        smem_rdata <= ram_rdata; // [R22]
      end
      ldma_gnt <= ldma_req && (ldma_gnt || (!sm_acc_reg && !sm_start && !rem_acc_reg)); // [R17]
    end
  end

  // ram port: one word per request, released the cycle after
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ram_en    <= 1'b0;
      ram_we    <= 1'b0;
      ram_addr  <= 16'h0000;
      ram_be    <= 2'b00;
      ram_wdata <= 16'h0000;
    end else begin
      ram_en <= sm_start || rem_issue; // [R12]
      ram_we <= 1'b0;
      if (sm_start) begin
        ram_we    <= smem_we;
        ram_addr  <= smem_addr[15:0] & win_mask;
        ram_be    <= smem_be;
        ram_wdata <= smem_wdata;
      end else if (state_reg == rdm_pkg::ST_HDR0) begin
        ram_addr <= {bound_reg, 8'h00};
        ram_be   <= 2'b11;
      end else if (state_reg == rdm_pkg::ST_HDR2) begin
        ram_addr <= {bound_reg, 8'h00} + rdm_pkg::HDR_CNT_OFS;
        ram_be   <= 2'b11;
      end else if (rem_issue) begin
        ram_we    <= mode_reg == rdm_pkg::MODE_WR; // [R3]
        ram_addr  <= cur_addr_reg;
        ram_be    <= word_mode ? 2'b11 : (cur_addr_reg[0] ? 2'b10 : 2'b01);
        ram_wdata <= word_mode ? latch_reg : {latch_reg[7:0], latch_reg[7:0]};
      end
    end
  end

  // ==========================================================
  // checks
  sequence rem_word_s;
    state_reg == rdm_pkg::ST_ACC;
  endsequence
  ram_excl_a: assert property (@(posedge mclk) disable iff (!rst_b) ram_en |-> !ldma_gnt) // [R13]
    else $error("ram used during local transfer");
  cnt_step_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R24]
    rem_word_s ##0 (cur_cnt_reg > step) |=> cur_cnt_reg == $past(cur_cnt_reg) - $past(step))
    else $error("count step wrong");
  wrap_addr_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R8]
    rem_word_s ##0 (mode_reg != rdm_pkg::MODE_WR && addr_inc[15:8] == pstop_reg)
    |=> cur_addr_reg == {pstart_reg, 8'h00})
    else $error("no wrap at page stop");
  rd_stall_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R10]
    port_rd && !latch_full_reg && !port_ack |=> !port_ack)
    else $error("read answered without data");
  wr_refuse_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R14]
    port_wr && latch_full_reg |=> !port_ack)
    else $error("write taken into full latch");
  sm_hold_a: assert property (@(posedge mclk) disable iff (!rst_b) ldma_gnt |-> !sm_start) // [R16]
    else $error("shared cycle during local transfer");
  sm_enable_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R18]
    smem_ack |-> $past(smctl1_reg[rdm_pkg::SM_EN_BIT], 2))
    else $error("shared answer while disabled");
  sm_first_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R17]
    sm_start ##1 ldma_req |-> !ldma_gnt ##1 smem_ack)
    else $error("local dma cut into shared cycle");
  send_load_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R6]
    state_reg == rdm_pkg::ST_HDR3 |=> cur_cnt_reg == $past(ram_rdata))
    else $error("header count not loaded");
  bound_adv_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R7]
    mode_reg == rdm_pkg::MODE_SEND && state_next == rdm_pkg::ST_IDLE && state_reg != rdm_pkg::ST_IDLE
    && !cmd_abort && !(wr_fire && awaddr == rdm_pkg::OFS_BOUND) |=> bound_reg == $past(next_page_reg))
    else $error("boundary not advanced");
endmodule

// [verif/rdm_ram_model.sv]
// buffer ram model: 512 bytes of asynchronous ram on the memory bus
// assumes ram_addr is a byte address and ram_en strobes one word
`timescale 1ns/1ps
module rdm_ram_model (
  input  wire logic        mclk,      // clock
  input  wire logic        ram_en,    // word strobe
  input  wire logic        ram_we,    // write
  input  wire logic [15:0] ram_addr,  // byte address
  input  wire logic [1:0]  ram_be,    // byte lanes
  input  wire logic [15:0] ram_wdata, // write data
  output logic      [15:0] ram_rdata  // read data
);
  // ==========
  // storage
  logic [15:0] mem [256];
  logic [15:0] last = 16'h5a5a;
  // unstrobed bus shows inverted junk, so stale data is never trusted
  assign ram_rdata = ram_en ? mem[ram_addr[8:1]] : ~last;
  // one word per strobe, lanes written separately
  always @(posedge mclk) begin
    if (ram_en) last <= ram_rdata;
    if (ram_en && ram_we && ram_be[0]) mem[ram_addr[8:1]][7:0] <= ram_wdata[7:0];
    if (ram_en && ram_we && ram_be[1]) mem[ram_addr[8:1]][15:8] <= ram_wdata[15:8];
  end
endmodule

// [verif/tb_top.sv]
// self-checking bench: axi registers, host data port, shared memory window
// assumes the ram model answers each strobe in the same cycle
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("mismatch %s exp %h got %h", n, e, g); \
  end \
end
module tb_top;
  logic        mclk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, smem_we = 0;
  logic        host_width_select_pin = 0, port_rd = 0, port_wr = 0, smem_req = 0, ldma_req = 0;
  logic        awready, wready, bvalid, arready, rvalid, port_ack, port_wait, smem_ack, smem_wait, ldma_gnt;
  logic        ram_en, ram_we;
  logic [7:0]  awaddr = 0, araddr = 0, b [4];
  logic [31:0] wdata = 0, rdata, r;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  smem_be = 2'b11, bresp, rresp, ram_be;
  logic [23:0] smem_addr = 0;
  logic [15:0] port_wdata = 0, smem_wdata = 0, port_rdata, smem_rdata, ram_addr, ram_wdata, ram_rdata, q;
  int          n_errors = 0, check_count = 0, cyc = 0, acks = 0, waits = 0;
  rdm_core u_dut (.*);
  rdm_ram_model u_ram (.*);
  // ==========
  // clock, timeout and ack counter
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (smem_ack === 1'b1) acks++;
    if (port_wait === 1'b1) waits++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  // axi write: hold each channel until taken, bready up until bvalid
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    `CHK("bresp", rdm_pkg::RESP_OK, bresp)
    bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    r = rdata;
    `CHK("rresp", rdm_pkg::RESP_OK, rresp)
    rready <= 1'b0;
    @(posedge mclk);
  endtask
  // extra edge after ack keeps the two-cycle request spacing
  task automatic prt(input logic wr, input logic [15:0] d);
    port_wr <= wr;
    port_rd <= !wr;
    port_wdata <= d;
    do @(posedge mclk); while (!port_ack);
    q = port_rdata;
    port_wr <= 1'b0;
    port_rd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic smr(input logic [23:0] a);
    smem_addr <= a;
    smem_req <= 1'b1;
    do @(posedge mclk); while (!smem_ack);
    q = smem_rdata;
    smem_req <= 1'b0;
    @(posedge mclk);
  endtask
  // four bytes from 0x0010, then the mode command
  task automatic go(input logic [7:0] mode, input logic [7:0] cfg);
    axw(rdm_pkg::OFS_CFG, cfg);
    axw(rdm_pkg::OFS_SADDR_LO, 8'h10);
    axw(rdm_pkg::OFS_CNT_LO, 8'h04);
    axw(rdm_pkg::OFS_CMD, mode);
  endtask
  // header bytes of the test frame: status, next page 1, count 4
  function automatic logic [7:0] hdr_byte(input int i, input logic [7:0] st);
    return 8'((32'h0004_0100 | {24'h00_0000, st}) >> (8 * i));
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    void'($urandom(32'h8c89_3e2f));
    foreach (b[i]) b[i] = 8'($urandom);
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    // ring ends at page 2, so the test pages 0 and 1 never wrap
    axw(rdm_pkg::OFS_PSTOP, 8'h02);
    go(8'h02, 8'h00);
    foreach (b[i]) prt(1'b1, {8'h00, b[i]});
    axr(rdm_pkg::OFS_CUR_CNT);
    `CHK("wr count", 32'h0000_0000, r)
    axr(rdm_pkg::OFS_CUR_ADDR);
    `CHK("wr addr", 32'h0000_0014, r)
    $display("test remote write done");
    go(8'h01, 8'h00);
    foreach (b[i]) begin
      prt(1'b0, 16'h0000);
      `CHK("rd byte", b[i], q[7:0])
    end
    host_width_select_pin <= 1'b1;
    go(8'h01, 8'h01);
    for (int i = 0; i < 4; i += 2) begin
      prt(1'b0, 16'h0000);
      `CHK("rd word", {b[i+1], b[i]}, q)
    end
    axr(rdm_pkg::OFS_CUR_CNT);
    `CHK("word count", 32'h0000_0000, r)
    $display("test remote read done");
    // shared window with the remote channel idle, base 5, narrow host
    host_width_select_pin <= 1'b0;
    axw(rdm_pkg::OFS_SMCTL1, 8'h05);
    smem_addr <= 24'h08_A010;
    smem_req <= 1'b1;
    repeat (8) @(posedge mclk);
    smem_req <= 1'b0;
    @(posedge mclk);
    `CHK("disabled acks", 0, acks)
    axw(rdm_pkg::OFS_SMCTL1, 8'h45);
    smr(24'h08_A010);
    `CHK("smem read", {b[1], b[0]}, q)
    ldma_req <= 1'b1;
    repeat (3) @(posedge mclk);
    smem_req <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK("smem held", 1'b1, smem_wait)
    `CHK("local grant", 1'b1, ldma_gnt)
    ldma_req <= 1'b0;
    smr(24'h08_A010);
    `CHK("smem after", {b[1], b[0]}, q)
    $display("test shared memory done");
    // send packet: header at page 0 written through the window, status random
    smem_we <= 1'b1;
    smem_wdata <= {8'h01, b[3]};
    smr(24'h08_A000);
    smem_wdata <= 16'h0004;
    smr(24'h08_A002);
    smem_we <= 1'b0;
    axw(rdm_pkg::OFS_CNT_HI, 8'h0F);
    axw(rdm_pkg::OFS_CMD, 8'h03);
    for (int i = 0; i < 4; i++) begin
      prt(1'b0, 16'h0000);
      `CHK("send byte", hdr_byte(i, b[3]), q[7:0])
    end
    `CHK("port stall", 1'b1, waits != 0)
    axr(rdm_pkg::OFS_BOUND);
    `CHK("boundary", 32'h0000_0001, r)
    $display("test send packet done");
    finish_test();
  end
endmodule
